// ### dv/fbs_frontend_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.vh"
// **********
// port checks of the slave front end
// **********
module fbs_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        tx_pin,
   input wire logic        tx_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rd;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data moved");
   property p_rdec;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > `FBS_AXI_STATUS
      |=> s_axi_rresp == `FBS_RESP_DEC && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_rdec: assert property (p_rdec) else $error("unmapped read");
   property p_rok;
      s_axi_arvalid && s_axi_arready && s_axi_araddr <= `FBS_AXI_STATUS
      && s_axi_araddr[1:0] == 2'b00 |=> s_axi_rresp == `FBS_RESP_OKAY;
   endproperty
   a_rok: assert property (p_rok) else $error("mapped read refused");
   property p_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
   endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write resp moved");
   property p_idle;
      !tx_oe |-> tx_pin;
   endproperty
   a_idle: assert property (p_idle) else $error("line not idle");
   property p_start;
      $rose(tx_oe) |-> !tx_pin;
   endproperty
   a_start: assert property (p_start) else $error("no start bit");
endmodule // fbs_chk
bind fbs_frontend fbs_chk fbs_chk_i (.*);
`default_nettype wire

// ### dv/fbs_master.sv
`timescale 1ns/1ps
`default_nettype none
// **********
// line master: sends 8n1 chars, collects reply chars
// **********
module fbs_master (
   input  wire logic clk,
   input  wire logic dut_tx,
   input  wire logic dut_oe,
   output var  logic line_rx
);
   int         bitc = 26;
   logic [7:0] rxq[$];
   logic [7:0] b;
   initial line_rx = 1'b1;
   // lsb first, stop bit high, line idle high between frames
   task automatic send(input logic [159:0] f, input int n);
      for (int k = 0; k < n; k++) begin
         for (int i = -1; i < 9; i++) begin
            line_rx <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : f[8*(n-1-k)+i];
            repeat (bitc) @(posedge clk);
         end
      end
   endtask
   // reply chars sampled mid bit while the driver is on
   initial forever begin
      @(posedge clk);
      if (dut_oe && !dut_tx) begin
         repeat (bitc / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (bitc) @(posedge clk);
            b[i] = dut_tx;
         end
         rxq.push_back(b);
         repeat (bitc) @(posedge clk);
      end
   end
endmodule // fbs_master
`default_nettype wire

// ### dv/fieldbus_slave_frontend_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.vh"
// **********
// bench: axi config plus rtu and ascii frames from the line master
// **********
module fieldbus_slave_frontend_test;
   logic        clk = 1'b0, rst_n = 1'b0, meas_fail = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, s, st;
   logic [31:0] s_axi_wdata = 32'h0000_0000, meas_value = 32'h0000_0000, d;
   logic [31:0] lf = 32'h0000_01ec;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [15:0] v;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, tx_pin, tx_oe, rx_pin;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   int          n_mismatch = 0, num_checks = 0;
   always #12.5 clk = ~clk;
   fbs_frontend #(.CLK_HZ(32'h0007_A120)) fbs_frontend_i (.*);
   fbs_master fbs_master_i (.clk(clk), .dut_tx(tx_pin), .dut_oe(tx_oe),
                            .line_rx(rx_pin));
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [15:0] crc(input logic [159:0] f, input int n);
      logic [15:0] c = `FBS_CRC_INIT;
      for (int k = 0; k < n; k++) begin
         c = c ^ {8'h00, f[8*(n-1-k)+:8]};
         for (int j = 0; j < 8; j++)
            c = c[0] ? (c >> 1) ^ `FBS_CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   task automatic conclude;
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tick(inout int t, input int lim);
      @(posedge clk);
      t++;
      if (t > lim) begin
         n_mismatch++;
         conclude();
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] dd);
      int t = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         tick(t, 50);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, `FBS_RESP_OKAY);
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] e);
      int t = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         tick(t, 50);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
   endtask
   // rtu frames get their crc appended, low byte first; ascii passes nc 0
   task automatic xfer(input logic [159:0] f, input int n,
                       input logic [159:0] e, input int ne, input int nc = 2);
      int t = 0;
      logic [15:0] c = crc(f, n);
      logic [15:0] ce = crc(e, ne);
      fbs_master_i.rxq.delete();
      if (nc > 0) begin
         f = {f[143:0], c[7:0], c[15:8]};
         e = {e[143:0], ce[7:0], ce[15:8]};
      end
      fbs_master_i.send(f, n + nc);
      while (tx_oe || t < 1500 ||
             (ne > 0 && fbs_master_i.rxq.size() < ne + nc))
         tick(t, 9000);
      chk(fbs_master_i.rxq.size(), (ne > 0) ? ne + nc : 0);
      for (int k = 0; k < fbs_master_i.rxq.size() && k < ne + nc; k++)
         chk(fbs_master_i.rxq[k], e[8*(ne+nc-1-k)+:8]);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      axr(8'h00, {16'h0000, `FBS_RST_STATION});
      axr(8'h04, {16'h0000, `FBS_RST_BAUD});
      for (int k = 2; k < 5; k++) axr(8'(4 * k), 32'h0000_0000);
      axr(8'h80, 32'h0000_0000);
      lf = nx(lf);
      s = 8'(lf % 247) + 8'h01;
      st = 8'(s % 247) + 8'h01;
      lf = nx(lf);
      v = lf[15:0];
      meas_value <= lf;
      axw(8'h00, {24'h00_0000, s});
      axw(8'h00, 32'h0000_00F8);
      axr(8'h00, {24'h00_0000, s});
      axw(8'h04, 32'h0000_0004);
      xfer({s, 40'h03_0000_0001}, 6, {s, 24'h03_0200, s}, 5);
      xfer({s, 24'h06_0004, v}, 6, {s, 24'h06_0004, v}, 6);
      axr(8'h10, {16'h0000, v});
      xfer({8'h00, 24'h06_0005, v}, 6, 160'h0, 0);
      axr(8'h14, {16'h0000, v});
      xfer({st, 24'h06_0006, v}, 6, 160'h0, 0);
      axr(8'h18, 32'h0000_0000);
      xfer({s, 40'h05_0000_FF00}, 6, {s, 16'h8501}, 3);
      xfer({s, 40'h08_0000_A55A}, 6, {s, 40'h08_0000_A55A}, 6);
      xfer({s, 80'h17_0007_0001_0007_0001_02, v}, 13,
           {s, 16'h1702, v}, 5);
      xfer({s, 48'h10_0008_0001_02, v}, 9, {s, 40'h10_0008_0001}, 6);
      axr(8'h20, {16'h0000, v});
      meas_fail <= 1'b1;
      meas_value <= ~lf;
      xfer({s, 40'h04_0000_0002}, 6, {s, 16'h0404, `FBS_NAN}, 7);
      axw(8'h0C, 32'h0000_0001);
      xfer({s, 40'h04_0000_0002}, 6, {s, 16'h0404, lf}, 7);
      axw(8'h00, 32'h0000_0001);
      axw(8'h08, 32'h0000_0001);
      xfer(":010300000001FB\015\n", 17, ":0103020001F9\015\n", 15, 0);
      conclude();
   end
endmodule // fieldbus_slave_frontend_test
`default_nettype wire

// ### verilog/fbs_defs.vh
`ifndef FBS_DEFS_VH
`define FBS_DEFS_VH
// **********
// protocol codes
// **********
`define FBS_FC_RD_HOLD 8'h03
`define FBS_FC_RD_INP  8'h04
`define FBS_FC_WR_ONE  8'h06
`define FBS_FC_DIAG    8'h08
`define FBS_FC_WR_MUL  8'h10
`define FBS_FC_RW_MUL  8'h17
`define FBS_EXC_FLAG   8'h80
`define FBS_EXC_FUNC   8'h01
`define FBS_EXC_ADDR   8'h02
`define FBS_BCAST      8'h00
`define FBS_ADDR_MIN   16'h0001
`define FBS_ADDR_MAX   16'h00F7
`define FBS_NREG       17'h0_0010
`define FBS_NAN        32'h7FC0_0000
`define FBS_CRC_INIT   16'hFFFF
`define FBS_CRC_POLY   16'hA001
`define FBS_RTU_GAP    6'h27
// **********
// ascii framing characters
// **********
`define FBS_CH_COLON   8'h3A
`define FBS_CH_CR      8'h0D
`define FBS_CH_LF      8'h0A
`define FBS_CH_0       8'h30
`define FBS_CH_9       8'h39
`define FBS_CH_A       8'h41
`define FBS_CH_F       8'h46
// **********
// holding registers: index and reset value
// **********
`define FBS_HR_STATION 4'h0
`define FBS_HR_BAUD    4'h1
`define FBS_HR_MODE    4'h2
`define FBS_HR_FSAFE   4'h3
`define FBS_RST_STATION 16'h0001
`define FBS_RST_BAUD   16'h0003
`define FBS_RST_MODE   16'h0000
`define FBS_RST_FSAFE  16'h0000
// **********
// axi map and line rates
// **********
`define FBS_AXI_STATUS 8'h40
`define FBS_RESP_OKAY  2'b00
`define FBS_RESP_DEC   2'b11
`define FBS_BAUD_0     32'h0000_04B0
`define FBS_BAUD_1     32'h0000_0960
`define FBS_BAUD_2     32'h0000_12C0
`define FBS_BAUD_3     32'h0000_2580
`define FBS_BAUD_4     32'h0000_4B00
`define FBS_BAUD_5     32'h0000_9600
`define FBS_BAUD_6     32'h0000_E100
`define FBS_BAUD_7     32'h0001_C200
`endif

// ### verilog/fbs_frontend.v
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.vh"
// What this block does
// [RL1] answers only as a slave at a station address settable in 1..247.
// [RL2] executes read holding, read input and diagnostics at own address.
// [RL3] executes write single and write multiple registers at own address.
// [RL4] read/write multiple writes first, then returns the read data.
// [RL5] address 0 is broadcast, acted on only for codes 06, 16 and 23.
// [RL6] line rate is one of eight selectable rates, 1200 to 115200 baud.
// [RL7] framing is ascii or rtu as configured.
// [RL8] a failed measurement reads as nan or last valid value, as selected.
// [RL9] every configuration value is readable and writable over the bus.
// [RL10] broadcasts get no reply and foreign addresses are ignored.
// [RL11] an unsupported code at own address gets an illegal-function reply.
module fbs_frontend #(
   parameter CLK_HZ = 32'h0262_5A00
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        rx_pin,
   output wire        tx_pin,
   output wire        tx_oe,
   input  wire [31:0] meas_value,
   input  wire        meas_fail
);
   localparam [2:0] S_RX = 3'h0, S_CHK = 3'h1, S_EXEC = 3'h2, S_TX = 3'h3;
   localparam [2:0] P_COL = 3'h0, P_DAT = 3'h1, P_CK1 = 3'h2, P_CK2 = 3'h3,
                    P_LF = 3'h4, P_END = 3'h5;
   // **********
   // helpers
   // **********
   function [15:0] crc_step(input [15:0] c, input [7:0] b);
      integer j;
      reg [15:0] x;
      begin
         x = c ^ {8'h00, b};
         for (j = 0; j < 8; j = j + 1)
            x = x[0] ? ((x >> 1) ^ `FBS_CRC_POLY) : (x >> 1);
         crc_step = x;
      end
   endfunction
   function [4:0] hexval(input [7:0] c);
      begin
         if (c >= `FBS_CH_0 && c <= `FBS_CH_9) hexval = {1'b1, c[3:0]};
         else if (c >= `FBS_CH_A && c <= `FBS_CH_F)
            hexval = {1'b1, c[3:0] + 4'h9};
         else hexval = 5'h00;
      end
   endfunction
   function [16:0] baud_div(input [2:0] s);
      reg [31:0] q;
      begin
         case (s)
            3'h0: q = CLK_HZ / `FBS_BAUD_0;
            3'h1: q = CLK_HZ / `FBS_BAUD_1;
            3'h2: q = CLK_HZ / `FBS_BAUD_2;
            3'h3: q = CLK_HZ / `FBS_BAUD_3;
            3'h4: q = CLK_HZ / `FBS_BAUD_4;
            3'h5: q = CLK_HZ / `FBS_BAUD_5;
            3'h6: q = CLK_HZ / `FBS_BAUD_6;
            default: q = CLK_HZ / `FBS_BAUD_7;
         endcase
         baud_div = q[16:0];
      end
   endfunction
   function cfg_ok(input [3:0] i, input [15:0] v);
      begin
         case (i)
            `FBS_HR_STATION: cfg_ok = v >= `FBS_ADDR_MIN &&
                                      v <= `FBS_ADDR_MAX; // [RL1]
            `FBS_HR_BAUD:    cfg_ok = v[15:3] == 13'h0000; // [RL6]
            `FBS_HR_MODE:    cfg_ok = v[15:1] == 15'h0000; // [RL7]
            `FBS_HR_FSAFE:   cfg_ok = v[15:1] == 15'h0000; // [RL8]
            default:         cfg_ok = 1'b1;
         endcase
      end
   endfunction
   // **********
   // state
   // **********
   reg  [15:0] hreg_r [0:15];
   reg  [7:0]  fbuf_r [0:31];
   reg  [2:0]  st_r, ph_r, baud_r;
   reg         asc_r, rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r, rx_busy_r;
   reg         rx_stb_r, asc_on_r, asc_hi_r, ovf_r, nib_r, tx_busy_r;
   reg  [16:0] rx_cnt_r, gap_cnt_r, tx_cnt_r;
   reg  [3:0]  rx_bit_r, asc_nib_r, tx_bit_r, rst_r, wst_r;
   reg  [7:0]  rx_sh_r, rx_byte_r, lrc_r, fc_r, exc_r, tsum_r;
   reg  [5:0]  gap_r, flen_r, tx_i_r, db_r, rlen_r;
   reg  [15:0] crc_r, tcrc_r, frm_cnt_r;
   reg  [4:0]  rcnt_r, wcnt_r, widx_r;
   reg         bc_r, oe_r;
   reg  [9:0]  tx_sh_r;
   reg  [31:0] last_r, rep_r;
   wire [16:0] div = baud_div(baud_r);
   wire [4:0]  hx = hexval(rx_stb_r ? rx_byte_r : 8'h00);
   // **********
   // axi4-lite slave
   // **********
   reg         awrdy_r, wrdy_r, aw_full_r, w_full_r, bvalid_r, arrdy_r;
   reg         rvalid_r;
   reg  [7:0]  aw_a_r;
   reg  [31:0] w_d_r, rdata_r;
   reg  [3:0]  w_s_r;
   reg  [1:0]  bresp_r, rresp_r;
   wire        wr_go = aw_full_r && w_full_r && !bvalid_r;
   wire        aw_hit = aw_a_r[7:6] == 2'b00;
   wire [3:0]  aw_idx = aw_a_r[5:2];
   wire [15:0] aw_val = {w_s_r[1] ? w_d_r[15:8] : hreg_r[aw_idx][15:8],
                         w_s_r[0] ? w_d_r[7:0] : hreg_r[aw_idx][7:0]};
   wire        axi_we = wr_go && aw_hit && cfg_ok(aw_idx, aw_val); // [RL9]
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awrdy_r <= 1'b1; wrdy_r <= 1'b1; aw_full_r <= 1'b0;
         w_full_r <= 1'b0; bvalid_r <= 1'b0; bresp_r <= `FBS_RESP_OKAY;
         arrdy_r <= 1'b1; rvalid_r <= 1'b0; rresp_r <= `FBS_RESP_OKAY;
         rdata_r <= 32'h0000_0000; aw_a_r <= 8'h00; w_d_r <= 32'h0000_0000;
         w_s_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && awrdy_r) begin
            aw_full_r <= 1'b1; awrdy_r <= 1'b0; aw_a_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wrdy_r) begin
            w_full_r <= 1'b1; wrdy_r <= 1'b0;
            w_d_r <= s_axi_wdata; w_s_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1; aw_full_r <= 1'b0; w_full_r <= 1'b0;
            bresp_r <= (aw_hit || aw_a_r == `FBS_AXI_STATUS) ?
                       `FBS_RESP_OKAY : `FBS_RESP_DEC;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0; awrdy_r <= 1'b1; wrdy_r <= 1'b1;
         end
         if (s_axi_arvalid && arrdy_r) begin
            arrdy_r <= 1'b0; rvalid_r <= 1'b1;
            rresp_r <= `FBS_RESP_OKAY;
            if (s_axi_araddr[7:6] == 2'b00)
               rdata_r <= {16'h0000, hreg_r[s_axi_araddr[5:2]]}; // [RL9]
            else if (s_axi_araddr == `FBS_AXI_STATUS)
               rdata_r <= {frm_cnt_r, 11'h000, meas_fail, oe_r, st_r};
            else begin
               rdata_r <= 32'h0000_0000; rresp_r <= `FBS_RESP_DEC;
            end
         end
         if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0; arrdy_r <= 1'b1;
         end
      end
   end
   // **********
   // holding registers: axi writes win over the bus engine
   // **********
   wire [5:0]  wpos = db_r + {widx_r, 1'b0};
   wire [3:0]  mb_wa = wst_r + widx_r[3:0];
   wire [15:0] mb_wd = {fbuf_r[wpos[4:0]], fbuf_r[wpos[4:0] + 5'h01]};
   wire        mb_we = st_r == S_EXEC && widx_r != wcnt_r && !axi_we;
   integer k;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (k = 0; k < 16; k = k + 1) hreg_r[k] <= 16'h0000;
         hreg_r[`FBS_HR_STATION] <= `FBS_RST_STATION;
         hreg_r[`FBS_HR_BAUD] <= `FBS_RST_BAUD;
         hreg_r[`FBS_HR_MODE] <= `FBS_RST_MODE;
         hreg_r[`FBS_HR_FSAFE] <= `FBS_RST_FSAFE;
      end else if (axi_we) hreg_r[aw_idx] <= aw_val;
      else if (mb_we && cfg_ok(mb_wa, mb_wd)) hreg_r[mb_wa] <= mb_wd; // [RL9]
   end
   // **********
   // frame check decode
   // **********
   wire [7:0]  fc = fbuf_r[1];
   wire [5:0]  plen = asc_r ? flen_r - 6'h01 : flen_r - 6'h02;
   wire        good = !ovf_r && (asc_r ? (lrc_r == 8'h00 && flen_r > 6'h02)
                                       : (crc_r == 16'h0000 && flen_r > 6'h03));
   wire        mine = fbuf_r[0] == hreg_r[`FBS_HR_STATION][7:0]; // [RL1]
   wire        bc = fbuf_r[0] == `FBS_BCAST; // [RL5]
   wire        is_rd = fc == `FBS_FC_RD_HOLD || fc == `FBS_FC_RD_INP ||
                       fc == `FBS_FC_RW_MUL;
   wire        is_wr = fc == `FBS_FC_WR_ONE || fc == `FBS_FC_WR_MUL ||
                       fc == `FBS_FC_RW_MUL;
   wire        sup = is_rd || is_wr || fc == `FBS_FC_DIAG; // [RL2] [RL3]
   wire [15:0] rs = {fbuf_r[2], fbuf_r[3]};
   wire [15:0] rq = {fbuf_r[4], fbuf_r[5]};
   wire [15:0] ws = fc == `FBS_FC_RW_MUL ? {fbuf_r[6], fbuf_r[7]} : rs;
   wire [15:0] wq = fc == `FBS_FC_RW_MUL ? {fbuf_r[8], fbuf_r[9]} :
                    fc == `FBS_FC_WR_ONE ? 16'h0001 : rq;
   wire [5:0]  db = fc == `FBS_FC_RW_MUL ? 6'h0B :
                    fc == `FBS_FC_WR_ONE ? 6'h04 : 6'h07;
   wire        rd_bad = is_rd && (rq == 16'h0000 ||
                        {1'b0, rs} + {1'b0, rq} > `FBS_NREG);
   wire        wr_bad = is_wr && (wq == 16'h0000 ||
                        {1'b0, ws} + {1'b0, wq} > `FBS_NREG ||
                        {11'h000, db} + {wq, 1'b0} > {11'h000, plen});
   // **********
   // reply byte stream
   // **********
   wire [5:0]  ko = tx_i_r - 6'h03;
   wire [3:0]  ridx = rst_r + ko[4:1];
   wire [15:0] rv = fc_r != `FBS_FC_RD_INP ? hreg_r[ridx] :
                    ridx == 4'h0 ? rep_r[31:16] :
                    ridx == 4'h1 ? rep_r[15:0] : 16'h0000;
   reg  [7:0]  rb, tch;
   always @* begin
      if (tx_i_r == 6'h00) rb = fbuf_r[0];
      else if (tx_i_r == 6'h01) rb = exc_r != 8'h00 ? fc_r | `FBS_EXC_FLAG
                                                    : fc_r;
      else if (exc_r != 8'h00) rb = exc_r; // [RL11]
      else if (fc_r == `FBS_FC_WR_ONE || fc_r == `FBS_FC_WR_MUL ||
               fc_r == `FBS_FC_DIAG) rb = fbuf_r[tx_i_r[4:0]]; // [RL3]
      else if (tx_i_r == 6'h02) rb = {2'b00, rcnt_r, 1'b0};
      else rb = ko[0] ? rv[7:0] : rv[15:8]; // [RL2] [RL4]
   end
   wire [7:0]  ckb = ph_r == P_DAT ? rb : asc_r ? 8'h00 - tsum_r :
                     ph_r == P_CK1 ? tcrc_r[7:0] : tcrc_r[15:8];
   wire [3:0]  nb = nib_r ? ckb[3:0] : ckb[7:4];
   always @* begin
      if (ph_r == P_COL) tch = `FBS_CH_COLON;
      else if (asc_r && ph_r == P_CK2) tch = `FBS_CH_CR;
      else if (ph_r == P_LF) tch = `FBS_CH_LF;
      else if (asc_r) tch = nb < 4'hA ? `FBS_CH_0 + {4'h0, nb}
                                     : `FBS_CH_A - 8'h0A + {4'h0, nb};
      else tch = ckb;
   end
   wire tx_go = st_r == S_TX && !tx_busy_r && ph_r != P_END;
   // **********
   // line: synchroniser, receiver, transmitter
   // **********
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_s1_r <= 1'b1; rx_s2_r <= 1'b1; rx_s3_r <= 1'b1; rx_lvl_r <= 1'b1;
         rx_busy_r <= 1'b0; rx_stb_r <= 1'b0; rx_cnt_r <= 17'h0_0000;
         rx_bit_r <= 4'h0; rx_sh_r <= 8'h00; rx_byte_r <= 8'h00;
         gap_cnt_r <= 17'h0_0000; gap_r <= 6'h00;
         tx_busy_r <= 1'b0; tx_cnt_r <= 17'h0_0000; tx_bit_r <= 4'h0;
         tx_sh_r <= 10'h3FF;
      end else begin
         rx_s1_r <= rx_pin; rx_s2_r <= rx_s1_r; rx_s3_r <= rx_s2_r;
         if (rx_s2_r == rx_s3_r) rx_lvl_r <= rx_s3_r;
         rx_stb_r <= 1'b0;
         if (!rx_busy_r) begin
            rx_cnt_r <= {1'b0, div[16:1]};
            rx_bit_r <= 4'h0;
            if (!rx_lvl_r) rx_busy_r <= 1'b1;
         end else if (rx_cnt_r != 17'h0_0000) rx_cnt_r <= rx_cnt_r - 17'h0_0001;
         else begin
            rx_cnt_r <= div - 17'h0_0001; // [RL6]
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0 && rx_lvl_r) rx_busy_r <= 1'b0;
            else if (rx_bit_r == 4'h9) begin
               rx_busy_r <= 1'b0; rx_stb_r <= rx_lvl_r; rx_byte_r <= rx_sh_r;
            end else if (rx_bit_r != 4'h0) rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
         end
         if (rx_busy_r) begin
            gap_cnt_r <= 17'h0_0000; gap_r <= 6'h00;
         end else if (gap_cnt_r == div - 17'h0_0001) begin
            gap_cnt_r <= 17'h0_0000;
            if (gap_r != `FBS_RTU_GAP) gap_r <= gap_r + 6'h01;
         end else gap_cnt_r <= gap_cnt_r + 17'h0_0001;
         if (tx_go) begin
            tx_busy_r <= 1'b1; tx_sh_r <= {1'b1, tch, 1'b0};
            tx_bit_r <= 4'hA; tx_cnt_r <= div - 17'h0_0001;
         end else if (tx_busy_r) begin
            if (tx_cnt_r != 17'h0_0000) tx_cnt_r <= tx_cnt_r - 17'h0_0001;
            else begin
               tx_cnt_r <= div - 17'h0_0001;
               tx_sh_r <= {1'b1, tx_sh_r[9:1]};
               tx_bit_r <= tx_bit_r - 4'h1;
               if (tx_bit_r == 4'h1) tx_busy_r <= 1'b0;
            end
         end
      end
   end
   // **********
   // frame engine
   // **********
   wire idle = flen_r == 6'h00 && !asc_on_r && !rx_busy_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= S_RX; ph_r <= P_COL; baud_r <= 3'h3; asc_r <= 1'b0;
         flen_r <= 6'h00; crc_r <= `FBS_CRC_INIT; lrc_r <= 8'h00;
         asc_on_r <= 1'b0; asc_hi_r <= 1'b0; asc_nib_r <= 4'h0; ovf_r <= 1'b0;
         fc_r <= 8'h00; exc_r <= 8'h00; bc_r <= 1'b0; rst_r <= 4'h0;
         wst_r <= 4'h0; rcnt_r <= 5'h00; wcnt_r <= 5'h00; widx_r <= 5'h00;
         db_r <= 6'h00; rlen_r <= 6'h00; tx_i_r <= 6'h00; nib_r <= 1'b0;
         tsum_r <= 8'h00; tcrc_r <= `FBS_CRC_INIT; oe_r <= 1'b0;
         frm_cnt_r <= 16'h0000; last_r <= `FBS_NAN; rep_r <= `FBS_NAN;
      end else begin
         if (!meas_fail) last_r <= meas_value;
         rep_r <= !meas_fail ? meas_value :
                  hreg_r[`FBS_HR_FSAFE][0] ? last_r : `FBS_NAN; // [RL8]
         case (st_r)
            S_RX: begin
               if (idle) begin
                  baud_r <= hreg_r[`FBS_HR_BAUD][2:0]; // [RL6]
                  asc_r <= hreg_r[`FBS_HR_MODE][0]; // [RL7]
               end
               if (rx_stb_r && asc_r) begin // [RL7]
                  if (rx_byte_r == `FBS_CH_COLON) begin
                     asc_on_r <= 1'b1; asc_hi_r <= 1'b0; flen_r <= 6'h00;
                     lrc_r <= 8'h00; ovf_r <= 1'b0;
                  end else if (rx_byte_r == `FBS_CH_LF && asc_on_r) begin
                     asc_on_r <= 1'b0; st_r <= S_CHK;
                  end else if (hx[4] && asc_on_r) begin
                     asc_hi_r <= !asc_hi_r; asc_nib_r <= hx[3:0];
                     if (asc_hi_r && flen_r[5]) ovf_r <= 1'b1;
                     else if (asc_hi_r) begin
                        fbuf_r[flen_r[4:0]] <= {asc_nib_r, hx[3:0]};
                        flen_r <= flen_r + 6'h01;
                        lrc_r <= lrc_r + {asc_nib_r, hx[3:0]};
                     end
                  end
               end else if (rx_stb_r) begin
                  if (flen_r[5]) ovf_r <= 1'b1;
                  else begin
                     fbuf_r[flen_r[4:0]] <= rx_byte_r;
                     flen_r <= flen_r + 6'h01;
                     crc_r <= crc_step(crc_r, rx_byte_r);
                  end
               end else if (!asc_r && gap_r == `FBS_RTU_GAP &&
                            flen_r != 6'h00) st_r <= S_CHK; // [RL7]
            end
            S_CHK: begin
               flen_r <= 6'h00; crc_r <= `FBS_CRC_INIT; ovf_r <= 1'b0;
               fc_r <= fc; bc_r <= bc; rst_r <= rs[3:0]; wst_r <= ws[3:0];
               rcnt_r <= is_rd ? rq[4:0] : 5'h00; widx_r <= 5'h00;
               wcnt_r <= is_wr ? wq[4:0] : 5'h00; db_r <= db;
               exc_r <= !sup ? `FBS_EXC_FUNC : (rd_bad || wr_bad) ?
                        `FBS_EXC_ADDR : 8'h00; // [RL11]
               rlen_r <= (!sup || rd_bad || wr_bad) ? 6'h03 :
                         is_rd ? 6'h03 + {rq[4:0], 1'b0} : 6'h06;
               ph_r <= asc_r ? P_COL : P_DAT; tx_i_r <= 6'h00; nib_r <= 1'b0;
               tsum_r <= 8'h00; tcrc_r <= `FBS_CRC_INIT;
               if (!good || !(mine || bc)) st_r <= S_RX; // [RL10]
               else if (bc && (!is_wr || fc == `FBS_FC_RW_MUL && rd_bad ||
                               wr_bad)) st_r <= S_RX; // [RL5]
               else begin
                  frm_cnt_r <= frm_cnt_r + 16'h0001;
                  st_r <= (sup && !rd_bad && !wr_bad) ? S_EXEC : S_TX;
               end
            end
            S_EXEC: begin
               if (widx_r == wcnt_r) begin
                  st_r <= bc_r ? S_RX : S_TX; // [RL10] [RL4]
                  ph_r <= asc_r ? P_COL : P_DAT;
               end else if (mb_we) widx_r <= widx_r + 5'h01; // [RL3]
            end
            S_TX: begin
               oe_r <= 1'b1;
               if (tx_go) begin
                  if (asc_r && (ph_r == P_DAT || ph_r == P_CK1) && !nib_r)
                     nib_r <= 1'b1;
                  else begin
                     nib_r <= 1'b0;
                     if (ph_r == P_DAT) begin
                        tsum_r <= tsum_r + rb;
                        tcrc_r <= crc_step(tcrc_r, rb);
                        tx_i_r <= tx_i_r + 6'h01;
                        if (tx_i_r == rlen_r - 6'h01) ph_r <= P_CK1;
                     end else if (ph_r == P_CK2) ph_r <= asc_r ? P_LF : P_END;
                     else if (ph_r == P_LF) ph_r <= P_END;
                     else ph_r <= ph_r + 3'h1;
                  end
               end else if (ph_r == P_END && !tx_busy_r) begin
                  oe_r <= 1'b0; st_r <= S_RX;
               end
            end
            default: st_r <= S_RX;
         endcase
      end
   end
   assign s_axi_awready = awrdy_r;
   assign s_axi_wready  = wrdy_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_arready = arrdy_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign tx_pin        = tx_sh_r[0];
   assign tx_oe         = oe_r;
endmodule // fbs_frontend
`default_nettype wire
